// ### rtl/acs_ctrl.sv
/*
 * Auto-scan threshold control: control register, compare and interrupt
 * mode handling, result store steering and analog request outputs.
 * Assumes a converter that reports enable/active state, scan start,
 * per-result valid and scan completion, all synchronous to core_clk_i.
 */
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module acs_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic adc_on_i,
  input wire logic adc_active_i,
  input wire logic scan_start_i,
  input wire logic scan_done_i,
  input wire acs_pkg::acs_result_t result_i,
  output logic autoscan_enable_o,
  output logic low_power_o,
  output logic charge_time_unit_request_o,
  output logic bandgap_request_o,
  output logic store_o,
  output logic store_slot_o,
  output logic [15:0] store_data_o,
  output logic irq_o
);
  import acs_pkg::*;

  // Word select, shared by every strobe and the read mux
  function automatic logic addr_hit(input logic [2:0] addr, input logic [2:0] off);
    return addr == off;
  endfunction : addr_hit

  // Analog request passes only while the converter is on and running,
  // so a stale bit cannot wake the analog side with the converter off
  function automatic logic req_gate(input logic req_bit, input logic live);
    return req_bit && live;
  endfunction : req_gate

  // Threshold events count only while auto-scan runs;
  // legacy stores deliberately bypass this gate
  function automatic logic scan_gate(input logic enable, input logic ev);
    return enable && ev;
  endfunction : scan_gate

  acs_ctrl_t ctrl_q;
  logic [15:0] buf_a_q;
  logic [15:0] buf_b_q;
  logic [15:0] rdata_q;
  logic low_power_q;
  logic ctu_req_q;
  logic bg_req_q;
  logic store_q;
  logic slot_q;
  logic [15:0] store_data_q;
  logic match_seen_q;

  // Address decode
  wire logic sel_ctrl_w = addr_hit(reg_addr_i, ACS_OFF_CTRL);
  wire logic sel_stat_w = addr_hit(reg_addr_i, ACS_OFF_STAT);
  wire logic sel_mask_w = addr_hit(reg_addr_i, ACS_OFF_MASK);
  wire logic sel_bufa_w = addr_hit(reg_addr_i, ACS_OFF_BUFA);
  wire logic sel_bufb_w = addr_hit(reg_addr_i, ACS_OFF_BUFB);

  wire logic ctrl_wr_w = reg_wr_i && sel_ctrl_w;
  wire logic bufa_wr_w = reg_wr_i && sel_bufa_w;
  wire logic bufb_wr_w = reg_wr_i && sel_bufb_w;
  wire logic mask_wr_w = reg_wr_i && sel_mask_w;
  wire logic stat_rd_w = reg_rd_i && sel_stat_w;

  // Unimplemented positions never store, so they read as zero
  wire acs_ctrl_t ctrl_d = ctrl_wr_w ? acs_ctrl_t'(reg_wdata_i & ACS_CTRL_MASK) : ctrl_q;

  // Converter on and running: gate for the analog requests
  wire logic adc_live_w = adc_on_i && adc_active_i;

  // Compare of the incoming result
  logic match_raw_w;
  acs_cmp u_cmp (
    .mode_i(ctrl_q.compare_mode),
    .value_i(result_i.data),
    .buf_a_i(buf_a_q),
    .buf_b_i(buf_b_q),
    .match_o(match_raw_w)
  );

  // Control fields by function
  wire acs_irq_mode_t irq_mode_w = ctrl_q.autoscan_irq_mode;
  wire acs_wr_mode_t wr_mode_w = ctrl_q.result_write_mode;
  wire logic lp_sel_w = ctrl_q.low_power_after_scan;

  // Auto-scan off means no threshold events at all
  wire logic scanning_w = ctrl_q.autoscan_enable;
  wire logic match_w = scan_gate(scanning_w, result_i.valid) && match_raw_w;
  wire logic done_w = scan_gate(scanning_w, scan_done_i);
  wire logic had_match_w = match_seen_q || match_w;

  // Interrupt mode selection
  logic mode_irq_w;
  always_comb begin
    case (irq_mode_w)
      ACS_IRQ_BOTH: mode_irq_w = done_w && had_match_w;
      ACS_IRQ_MATCH: mode_irq_w = match_w;
      ACS_IRQ_DONE: mode_irq_w = done_w;
      ACS_IRQ_NONE: mode_irq_w = 1'b0;
      default: mode_irq_w = 1'b0;
    endcase
  end

  // Store steering per write mode
  logic store_w;
  logic slot_w;
  always_comb begin
    store_w = 1'b0;
    slot_w = 1'b0;
    case (wr_mode_w)
      ACS_WR_LEGACY: begin
        store_w = result_i.valid;
        slot_w = 1'b0;
      end
      ACS_WR_SAVE: begin
        store_w = scan_gate(scanning_w, result_i.valid);
        slot_w = match_raw_w;
      end
      ACS_WR_CMPONLY: begin
        store_w = 1'b0;
        slot_w = 1'b0;
      end
      // Reserved code: no stores, compares still run
      ACS_WR_RSVD: begin
        store_w = 1'b0;
        slot_w = 1'b0;
      end
      default: begin
        store_w = 1'b0;
        slot_w = 1'b0;
      end
    endcase
  end

  // Low power entered at scan end, left when the next scan starts
  wire logic low_power_d = (done_w && lp_sel_w) ? 1'b1 :
                           (scan_start_i || !lp_sel_w) ? 1'b0 :
                           low_power_q;

  // Match history for the combined interrupt, reset per scan
  wire logic match_seen_d = (done_w || scan_start_i) ? 1'b0 : had_match_w;

  // Status bit order is fixed by the package
  logic [2:0] events_w;
  assign events_w[ACS_EV_MATCH] = match_w;
  assign events_w[ACS_EV_DONE] = done_w;
  assign events_w[ACS_EV_IRQ] = mode_irq_w;

  logic [2:0] status_w;
  logic [2:0] mask_w;
  acs_irq u_irq (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .event_i(events_w),
    .stat_rd_i(stat_rd_w),
    .mask_wr_i(mask_wr_w),
    .mask_wdata_i(reg_wdata_i[2:0]),
    .status_o(status_w),
    .mask_o(mask_w),
    .irq_o(irq_o)
  );

  // Read-back views; unmapped words return zero
  wire logic [15:0] ctrl_view_w = 16'(ctrl_q) & ACS_CTRL_MASK;
  wire logic [15:0] stat_view_w = {13'h0000, status_w};
  wire logic [15:0] mask_view_w = {13'h0000, mask_w};
  wire logic [15:0] rmux_w =
    sel_ctrl_w ? ctrl_view_w :
    sel_stat_w ? stat_view_w :
    sel_mask_w ? mask_view_w :
    sel_bufa_w ? buf_a_q :
    sel_bufb_w ? buf_b_q :
    16'h0000;

  // Next values; each flop below holds exactly one register
  wire logic [15:0] buf_a_d = bufa_wr_w ? reg_wdata_i : buf_a_q;
  wire logic [15:0] buf_b_d = bufb_wr_w ? reg_wdata_i : buf_b_q;
  // Read data stands only in the cycle after the strobe
  wire logic [15:0] rdata_d = reg_rd_i ? rmux_w : 16'h0000;
  // Requests are registered so the analog side never sees decode glitches
  wire logic ctu_req_d = req_gate(ctrl_q.charge_time_unit_request, adc_live_w);
  wire logic bg_req_d = req_gate(ctrl_q.bandgap_request, adc_live_w);
  // Last stored word is held between stores
  wire logic [15:0] store_data_d = store_w ? result_i.data : store_data_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= acs_ctrl_t'(ACS_CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_a_q <= ACS_BUF_RST;
    end else begin
      buf_a_q <= buf_a_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_b_q <= ACS_BUF_RST;
    end else begin
      buf_b_q <= buf_b_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_power_q <= 1'b0;
    end else begin
      low_power_q <= low_power_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      match_seen_q <= 1'b0;
    end else begin
      match_seen_q <= match_seen_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctu_req_q <= 1'b0;
    end else begin
      ctu_req_q <= ctu_req_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bg_req_q <= 1'b0;
    end else begin
      bg_req_q <= bg_req_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      store_q <= 1'b0;
    end else begin
      store_q <= store_w;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_q <= 1'b0;
    end else begin
      slot_q <= slot_w;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      store_data_q <= 16'h0000;
    end else begin
      store_data_q <= store_data_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign autoscan_enable_o = ctrl_q.autoscan_enable;
  assign low_power_o = low_power_q;
  assign charge_time_unit_request_o = ctu_req_q;
  assign bandgap_request_o = bg_req_q;
  assign store_o = store_q;
  assign store_slot_o = slot_q;
  assign store_data_o = store_data_q;

endmodule : acs_ctrl

// ### include/acs_pkg.sv
/*
 * Shared constants and types for the auto-scan threshold control block:
 * register offsets, control field positions, reset values and mode codes.
 * Assumes a 16-bit register port with a 3-bit word address.
 */
package acs_pkg;

  localparam int unsigned ACS_DW = 16;
  localparam int unsigned ACS_AW = 3;

  // Register word offsets
  localparam logic [2:0] ACS_OFF_CTRL = 3'h0;
  localparam logic [2:0] ACS_OFF_STAT = 3'h1;
  localparam logic [2:0] ACS_OFF_MASK = 3'h2;
  localparam logic [2:0] ACS_OFF_BUFA = 3'h3;
  localparam logic [2:0] ACS_OFF_BUFB = 3'h4;

  // Control field positions
  localparam int unsigned ACS_POS_SCAN_EN = 15;
  localparam int unsigned ACS_POS_LOW_PWR = 14;
  localparam int unsigned ACS_POS_CTREQ = 13;
  localparam int unsigned ACS_POS_BG_REQ = 12;
  localparam int unsigned ACS_POS_IRQM = 8;
  localparam int unsigned ACS_POS_WR_MODE = 2;
  localparam int unsigned ACS_POS_CMP_MODE = 0;

  // Implemented control bits; all others read as zero
  localparam logic [15:0] ACS_CTRL_MASK = 16'hf30f;

  // Reset values
  localparam logic [15:0] ACS_CTRL_RST = 16'h0000;
  localparam logic [2:0] ACS_STAT_RST = 3'h0;
  localparam logic [2:0] ACS_MASK_RST = 3'h0;
  localparam logic [15:0] ACS_BUF_RST = 16'h0000;

  // Status bit positions
  localparam int unsigned ACS_EV_MATCH = 0;
  localparam int unsigned ACS_EV_DONE = 1;
  localparam int unsigned ACS_EV_IRQ = 2;
  localparam int unsigned ACS_NEV = 3;

  typedef enum logic [1:0] {
    ACS_IRQ_NONE = 2'b00,
    ACS_IRQ_DONE = 2'b01,
    ACS_IRQ_MATCH = 2'b10,
    ACS_IRQ_BOTH = 2'b11
  } acs_irq_mode_t;

  typedef enum logic [1:0] {
    ACS_WR_LEGACY = 2'b00,
    ACS_WR_SAVE = 2'b01,
    ACS_WR_CMPONLY = 2'b10,
    ACS_WR_RSVD = 2'b11
  } acs_wr_mode_t;

  typedef enum logic [1:0] {
    ACS_CMP_LESS = 2'b00,
    ACS_CMP_GREATER = 2'b01,
    ACS_CMP_INSIDE = 2'b10,
    ACS_CMP_OUTSIDE = 2'b11
  } acs_cmp_mode_t;

  typedef struct packed {
    logic autoscan_enable;
    logic low_power_after_scan;
    logic charge_time_unit_request;
    logic bandgap_request;
    logic [1:0] rsvd_hi;
    acs_irq_mode_t autoscan_irq_mode;
    logic [3:0] rsvd_mid;
    acs_wr_mode_t result_write_mode;
    acs_cmp_mode_t compare_mode;
  } acs_ctrl_t;

  // One conversion result handed in by the converter
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } acs_result_t;

endpackage : acs_pkg

// ### rtl/acs_cmp.sv
/*
 * Threshold comparator: judges one conversion result against the buffer
 * pair under the selected compare mode. Purely combinational; the caller
 * registers the outcome.
 */
`timescale 1ns/1ps
module acs_cmp (
  input wire acs_pkg::acs_cmp_mode_t mode_i,
  input wire logic [15:0] value_i,
  input wire logic [15:0] buf_a_i,
  input wire logic [15:0] buf_b_i,
  output logic match_o
);
  import acs_pkg::*;

  // Window bounds taken in either order, so a swapped pair still works
  wire logic [15:0] lo_w = (buf_a_i <= buf_b_i) ? buf_a_i : buf_b_i;
  wire logic [15:0] hi_w = (buf_a_i <= buf_b_i) ? buf_b_i : buf_a_i;
  wire logic inside_w = (value_i >= lo_w) && (value_i <= hi_w);

  always_comb begin
    case (mode_i)
      ACS_CMP_OUTSIDE: match_o = !inside_w;
      ACS_CMP_INSIDE: match_o = inside_w;
      ACS_CMP_GREATER: match_o = value_i > buf_a_i;
      ACS_CMP_LESS: match_o = value_i < buf_a_i;
      default: match_o = 1'b0;
    endcase
  end

endmodule : acs_cmp

// ### rtl/acs_irq.sv
/*
 * Sticky event status with mask and one level interrupt. A status read
 * clears the bits it returned; a new event in that cycle survives.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module acs_irq (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] event_i,
  input wire logic stat_rd_i,
  input wire logic mask_wr_i,
  input wire logic [2:0] mask_wdata_i,
  output logic [2:0] status_o,
  output logic [2:0] mask_o,
  output logic irq_o
);
  import acs_pkg::*;

  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic irq_q;

  // Set wins over the read-clear
  wire logic [2:0] status_d = (stat_rd_i ? 3'h0 : status_q) | event_i;
  wire logic [2:0] mask_d = mask_wr_i ? mask_wdata_i : mask_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= ACS_STAT_RST;
      mask_q <= ACS_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= |(status_d & mask_d);
    end
  end

  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = irq_q;

endmodule : acs_irq

// ### verif/acs_ctrl_sva.sv
/* Checker for acs_ctrl: register port, request lag and store timing.
   Assumes CTRL changes only through the register port. */
`timescale 1ns/1ps
module acs_ctrl_sva (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic adc_on_i,
  input wire logic adc_active_i,
  input wire logic scan_start_i,
  input wire logic scan_done_i,
  input wire acs_pkg::acs_result_t result_i,
  input wire logic autoscan_enable_o,
  input wire logic low_power_o,
  input wire logic charge_time_unit_request_o,
  input wire logic bandgap_request_o,
  input wire logic store_o,
  input wire logic store_slot_o,
  input wire logic [15:0] store_data_o,
  input wire logic irq_o
);
  import acs_pkg::*;
  logic [15:0] ctl_q;
  wire ctl_wr = reg_wr_i && reg_addr_i == ACS_OFF_CTRL;
  wire act = adc_on_i && adc_active_i;
  // Shadow of CTRL, so rules can be judged from the ports alone
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_q <= ACS_CTRL_RST;
    end else if (ctl_wr) begin
      ctl_q <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  enable_follow_a:
    assert property (ctl_wr |=> autoscan_enable_o == $past(reg_wdata_i[15]))
    else $error("autoscan enable does not follow write");
  ctu_req_a:
    assert property (charge_time_unit_request_o == $past(ctl_q[13] && act))
    else $error("charge time request wrong");
  bg_req_a:
    assert property (bandgap_request_o == $past(ctl_q[12] && act))
    else $error("bandgap request wrong");
  lp_set_a:
    assert property (scan_done_i && ctl_q[15] && ctl_q[14] && !ctl_wr |=> low_power_o)
    else $error("low power not entered after scan");
  lp_off_a:
    assert property (!ctl_q[14] [*2] |=> !low_power_o)
    else $error("low power without enable");
  unmapped_rd_a:
    assert property (reg_rd_i && reg_addr_i > ACS_OFF_BUFB |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  ctrl_rdback_a:
    assert property (reg_rd_i && reg_addr_i == ACS_OFF_CTRL
      |=> reg_rdata_o == ($past(ctl_q) & ACS_CTRL_MASK))
    else $error("control readback wrong");
  cmp_nostore_a:
    assert property (result_i.valid && ctl_q[3] |=> !store_o)
    else $error("store in compare-only or reserved mode");
  legacy_store_a:
    assert property (result_i.valid && ctl_q[3:2] == ACS_WR_LEGACY
      |=> store_o && !store_slot_o && store_data_o == $past(result_i.data))
    else $error("legacy store wrong");
  save_store_a:
    assert property (result_i.valid && ctl_q[15] && ctl_q[3:2] == ACS_WR_SAVE
      |=> store_o && store_data_o == $past(result_i.data))
    else $error("save mode store wrong");
  lp_clear_a:
    assert property (scan_start_i && !scan_done_i |=> !low_power_o)
    else $error("low power kept after scan start");
  irq_quiet_a:
    assert property (!ctl_q[15] && !irq_o && !(reg_wr_i && reg_addr_i == ACS_OFF_MASK)
      |=> !irq_o)
    else $error("interrupt raised with auto-scan off");
endmodule : acs_ctrl_sva

bind acs_ctrl acs_ctrl_sva i_sva (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .adc_on_i(adc_on_i),
  .adc_active_i(adc_active_i), .scan_start_i(scan_start_i), .scan_done_i(scan_done_i),
  .result_i(result_i), .autoscan_enable_o(autoscan_enable_o), .low_power_o(low_power_o),
  .charge_time_unit_request_o(charge_time_unit_request_o),
  .bandgap_request_o(bandgap_request_o), .store_o(store_o), .store_slot_o(store_slot_o),
  .store_data_o(store_data_o), .irq_o(irq_o));

// ### verif/test_acs_ctrl.sv
/* Testbench for acs_ctrl: register tasks and converter event pulses.
   Assumes the bound checker is compiled beside it. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_acs_ctrl;
  import acs_pkg::*;
  logic core_clk_i = 0, rst_i = 1, wr = 0, rd = 0, on = 1, act = 1, start = 0, done = 0;
  logic [2:0] addr = '0;
  logic [15:0] wdata = '0, rdata, sdata;
  acs_result_t res = '0;
  logic scan_en, lp, ctu, bg, st, slot, irq;
  int n_fail = 0, checks = 0, cyc = 0;
  logic [15:0] vals [3] = '{16'h0080, 16'h0180, 16'h0100};
  logic [3:0] hits [3] = '{4'h9, 4'h6, 4'h4};
  acs_ctrl i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .adc_on_i(on), .adc_active_i(act), .scan_start_i(start), .scan_done_i(done),
    .result_i(res), .autoscan_enable_o(scan_en), .low_power_o(lp),
    .charge_time_unit_request_o(ctu), .bandgap_request_o(bg), .store_o(st),
    .store_slot_o(slot), .store_data_o(sdata), .irq_o(irq));
  task automatic print_verdict();
    $display("TB: checks %0d errors %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [15:0] e, input bit chk = 1);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    @(negedge core_clk_i);
    if (chk) `CHK("rdata", e, rdata)
  endtask : rd_reg
  // k: 0 result, 1 scan start, 2 scan done; returns in the answer cycle
  task automatic ev(input int k, input logic [15:0] d);
    @(posedge core_clk_i);
    res <= '{valid: k == 0, data: d};
    start <= (k == 1);
    done <= (k == 2);
    @(posedge core_clk_i);
    res.valid <= 1'b0;
    start <= 1'b0;
    done <= 1'b0;
    @(negedge core_clk_i);
  endtask : ev
  initial forever #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_reg(ACS_OFF_CTRL, 16'h0000);
    rd_reg(ACS_OFF_STAT, 16'h0000);
    rd_reg(ACS_OFF_MASK, 16'h0000);
    wr_reg(ACS_OFF_CTRL, 16'hffff);
    rd_reg(ACS_OFF_CTRL, ACS_CTRL_MASK);
    `CHK("scan_en", 1'b1, scan_en)
    `CHK("ctu", 1'b1, ctu)
    `CHK("bg", 1'b1, bg)
    @(posedge core_clk_i);
    act <= 1'b0;
    repeat (2) @(negedge core_clk_i);
    `CHK("ctu", 1'b0, ctu)
    `CHK("bg", 1'b0, bg)
    @(posedge core_clk_i);
    act <= 1'b1;
    wr_reg(3'h7, 16'hffff);
    rd_reg(3'h7, 16'h0000);
    wr_reg(ACS_OFF_BUFA, 16'h0100);
    wr_reg(ACS_OFF_BUFB, 16'h0200);
    wr_reg(ACS_OFF_MASK, 16'h0004);
    // Boundary value 0x100 separates inclusive window from strict compares
    for (int cm = 0; cm < 4; cm++) begin
      wr_reg(ACS_OFF_CTRL, 16'h8004 | 16'(cm));
      for (int v = 0; v < 3; v++) begin
        ev(0, vals[v]);
        `CHK("store", 1'b1, st)
        `CHK("sdata", vals[v], sdata)
        `CHK("slot", hits[v][cm], slot)
      end
    end
    wr_reg(ACS_OFF_CTRL, 16'h8208);
    rd_reg(ACS_OFF_STAT, 16'h0000, 0);
    ev(0, 16'h0080);
    `CHK("store", 1'b0, st)
    repeat (2) @(negedge core_clk_i);
    `CHK("irq", 1'b1, irq)
    rd_reg(ACS_OFF_STAT, 16'h0005);
    repeat (2) @(negedge core_clk_i);
    `CHK("irq", 1'b0, irq)
    wr_reg(ACS_OFF_CTRL, 16'h800c);
    ev(0, 16'h0080);
    `CHK("store", 1'b0, st)
    for (int m = 0; m < 4; m++) begin
      wr_reg(ACS_OFF_CTRL, 16'h8000 | 16'(m) << 8);
      rd_reg(ACS_OFF_STAT, 16'h0000, 0);
      ev(1, 16'h0000);
      ev(0, 16'h0180);
      ev(2, 16'h0000);
      repeat (2) @(negedge core_clk_i);
      `CHK("irq", m == 1, irq)
      rd_reg(ACS_OFF_STAT, 16'h0000, 0);
      ev(1, 16'h0000);
      ev(0, 16'h0080);
      repeat (2) @(negedge core_clk_i);
      `CHK("irq", m == 2, irq)
      ev(2, 16'h0000);
      repeat (2) @(negedge core_clk_i);
      `CHK("irq", m != 0, irq)
    end
    wr_reg(ACS_OFF_CTRL, 16'hc000);
    ev(2, 16'h0000);
    `CHK("lp", 1'b1, lp)
    ev(1, 16'h0000);
    `CHK("lp", 1'b0, lp)
    wr_reg(ACS_OFF_CTRL, 16'h8000);
    ev(2, 16'h0000);
    `CHK("lp", 1'b0, lp)
    wr_reg(ACS_OFF_CTRL, 16'h0004);
    ev(0, 16'h0080);
    `CHK("scan_en", 1'b0, scan_en)
    `CHK("store", 1'b0, st)
    wr_reg(ACS_OFF_CTRL, 16'h0000);
    ev(0, 16'h0123);
    `CHK("store", 1'b1, st)
    `CHK("sdata", 16'h0123, sdata)
    print_verdict();
  end
endmodule : test_acs_ctrl
